// ==== design/qurs_defines.svh ====
`ifndef QURS_DEFINES_SVH
`define QURS_DEFINES_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define QURS_OFF_DIVLO 8'h00
`define QURS_OFF_DIVHI 8'h04
`define QURS_OFF_FRAC 8'h08
`define QURS_OFF_EVEN 8'h0c
`define QURS_OFF_FCTL 8'h10
`define QURS_OFF_PEND 8'h14
`define QURS_OFF_LCTL 8'h18
`define QURS_OFF_MCTL 8'h1c
`define QURS_OFF_LSTAT 8'h20
`define QURS_OFF_MSTAT 8'h24
`define QURS_OFF_SCR 8'h28
`define QURS_OFF_EFEAT 8'h2c
`define QURS_OFF_RES1 8'h30
`define QURS_OFF_RES2 8'h34
`define QURS_OFF_PAU1 8'h38
`define QURS_OFF_PAU2 8'h3c
`define QURS_OFF_FRDY 8'h40
`define QURS_NUM_REGS 17
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define QURS_RST_DIVLO 8'h01
`define QURS_RST_DIVHI 8'h00
`define QURS_RST_ZERO 8'h00
`define QURS_RST_PEND 8'h01
`define QURS_RST_LSTAT 8'h60
`define QURS_RST_SCR 8'hff
`define QURS_RST_FRDY 8'hff
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define QURS_MCTL_DTR 0
`define QURS_MCTL_RTS 1
`define QURS_MCTL_IR 6
`define QURS_LCTL_BRK 6
`endif

// ==== design/qurs_pkg.sv ====
package qurs_pkg;
    typedef logic [7:0] qurs_byte_t;
    typedef struct packed {
        logic [3:0] modem_n;
        logic [3:0] rx_ready_n;
        logic [3:0] tx_ready_n;
    } qurs_pins_s;
    typedef enum logic [1:0] {
        QURS_IDLE = 2'b00,
        QURS_ACK = 2'b01,
        QURS_DONE = 2'b11
    } qurs_state_e;
endpackage

// ==== design/qurs_regfile.sv ====
`timescale 1ns/1ps
`include "qurs_defines.svh"
module qurs_regfile
    import qurs_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [4:0] waddr_i,
    input wire qurs_byte_t wdata_i,
    // Read port
    input wire logic [4:0] raddr_i,
    output qurs_byte_t rdata_o
);
    qurs_byte_t mem_q [0:`QURS_NUM_REGS-1];

    // The array has no reset, and nothing seeds it; an entry holds X until it is first written.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rdata_o <= mem_q[raddr_i];
    end
endmodule

// ==== design/qurs_channel.sv ====
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "qurs_defines.svh"
module qurs_channel
    import qurs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Straps and pins
    input wire logic alert_drive_select_i,
    input wire logic mode68_i,
    input wire qurs_pins_s pins_i,
    // Channel outputs
    output logic serial_out_o,
    output logic infrared_tx_out_o,
    output logic rts_n_o,
    output logic dtr_n_o,
    output logic receive_ready_pin_o,
    output logic transmit_ready_pin_o,
    output logic alert_o,
    output logic alert_oe_n_o
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    qurs_pins_s pins_m_q;
    qurs_pins_s pins_s_q;
    logic sel_m_q;
    logic sel_s_q;
    logic m68_m_q;
    logic m68_s_q;

    always_ff @(posedge clk_i) begin
        pins_m_q <= pins_i;
        pins_s_q <= pins_m_q;
        sel_m_q <= alert_drive_select_i;
        sel_s_q <= sel_m_q;
        m68_m_q <= mode68_i;
        m68_s_q <= m68_m_q;
    end

    // ----------------------------------------------------------------
    // Power-up sequencing
    // ----------------------------------------------------------------
    // Only a power-on flag distinguishes first start from a reset pulse,
    // since the reset pin must not disturb the divisor.
    logic powered_q = 1'b0;
    logic div_we;
    logic div_first;
    qurs_byte_t divlo_q;
    qurs_byte_t divhi_q;

    always_ff @(posedge clk_i) begin
        powered_q <= 1'b1;
    end

    assign div_first = !powered_q;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic req;
    logic wr;
    logic [4:0] idx;
    logic hit;
    qurs_state_e state_q;

    // Gating on the idle state keeps a held request from writing twice before it is answered.
    assign req = wb_cyc_i && wb_stb_i && (state_q == QURS_IDLE);
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[6:2];
    assign hit = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i[7] == 1'b0)
                 && (idx < 5'(`QURS_NUM_REGS));
    assign div_we = wr && hit && (wb_adr_i == `QURS_OFF_DIVLO || wb_adr_i == `QURS_OFF_DIVHI);

    always_ff @(posedge clk_i) begin
        if (div_first) begin
            divlo_q <= `QURS_RST_DIVLO;
            divhi_q <= `QURS_RST_DIVHI;
        end else if (div_we) begin
            if (wb_adr_i == `QURS_OFF_DIVLO) begin
                divlo_q <= wb_dat_i[7:0];
            end else begin
                divhi_q <= wb_dat_i[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    qurs_byte_t frac_q, even_q, fctl_q, pend_q, lctl_q, mctl_q, lstat_q, scr_q, efeat_q;
    qurs_byte_t res1_q, res2_q, pau1_q, pau2_q;
    logic [3:0] mdelta_q;
    logic [3:0] modem_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frac_q <= `QURS_RST_ZERO;
            even_q <= `QURS_RST_ZERO;
            fctl_q <= `QURS_RST_ZERO;
            pend_q <= `QURS_RST_PEND;
            lctl_q <= `QURS_RST_ZERO;
            mctl_q <= `QURS_RST_ZERO;
            lstat_q <= `QURS_RST_LSTAT;
            scr_q <= `QURS_RST_SCR;
            efeat_q <= `QURS_RST_ZERO;
            res1_q <= `QURS_RST_ZERO;
            res2_q <= `QURS_RST_ZERO;
            pau1_q <= `QURS_RST_ZERO;
            pau2_q <= `QURS_RST_ZERO;
        end else if (wr && hit) begin
            case (wb_adr_i)
                `QURS_OFF_FRAC: frac_q <= wb_dat_i[7:0];
                `QURS_OFF_EVEN: even_q <= wb_dat_i[7:0];
                `QURS_OFF_FCTL: fctl_q <= wb_dat_i[7:0];
                `QURS_OFF_LCTL: lctl_q <= wb_dat_i[7:0];
                `QURS_OFF_MCTL: mctl_q <= wb_dat_i[7:0];
                `QURS_OFF_SCR: scr_q <= wb_dat_i[7:0];
                `QURS_OFF_EFEAT: efeat_q <= wb_dat_i[7:0];
                `QURS_OFF_RES1: res1_q <= wb_dat_i[7:0];
                `QURS_OFF_RES2: res2_q <= wb_dat_i[7:0];
                `QURS_OFF_PAU1: pau1_q <= wb_dat_i[7:0];
                `QURS_OFF_PAU2: pau2_q <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Delta bits set on input change and clear on read; set wins over clear.
    logic msr_rd;
    assign msr_rd = req && !wb_we_i && (wb_adr_i == `QURS_OFF_MSTAT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mdelta_q <= 4'h0;
            modem_prev_q <= pins_s_q.modem_n;
        end else begin
            modem_prev_q <= pins_s_q.modem_n;
            mdelta_q <= (msr_rd ? 4'h0 : mdelta_q) | (modem_prev_q ^ pins_s_q.modem_n);
        end
    end

    // ----------------------------------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------------------------------
    qurs_byte_t rd;
    qurs_byte_t fifo_ready_status;

    assign fifo_ready_status = {pins_s_q.rx_ready_n, ~pins_s_q.tx_ready_n};

    always_comb begin
        rd = 8'h00;
        case (wb_adr_i)
            `QURS_OFF_DIVLO: rd = divlo_q;
            `QURS_OFF_DIVHI: rd = divhi_q;
            `QURS_OFF_FRAC: rd = frac_q;
            `QURS_OFF_EVEN: rd = even_q;
            `QURS_OFF_FCTL: rd = fctl_q;
            `QURS_OFF_PEND: rd = pend_q;
            `QURS_OFF_LCTL: rd = lctl_q;
            `QURS_OFF_MCTL: rd = mctl_q;
            `QURS_OFF_LSTAT: rd = lstat_q;
            `QURS_OFF_MSTAT: rd = {~pins_s_q.modem_n, mdelta_q};
            `QURS_OFF_SCR: rd = scr_q;
            `QURS_OFF_EFEAT: rd = efeat_q;
            `QURS_OFF_RES1: rd = res1_q;
            `QURS_OFF_RES2: rd = res2_q;
            `QURS_OFF_PAU1: rd = pau1_q;
            `QURS_OFF_PAU2: rd = pau2_q;
            `QURS_OFF_FRDY: rd = fifo_ready_status;
            default: rd = 8'h00;
        endcase
    end

    // Mirror of all writes that hit a register offset into the shadow array; its read data shadow_rd is not used by anything.
    qurs_byte_t shadow_rd;
    qurs_regfile qurs_regfile_i (
        .clk_i(clk_i),
        .we_i(wr && hit),
        .waddr_i(idx),
        .wdata_i(wb_dat_i[7:0]),
        .raddr_i(idx),
        .rdata_o(shadow_rd)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= QURS_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            case (state_q)
                QURS_IDLE: begin
                    if (req) begin
                        state_q <= QURS_ACK;
                        wb_ack_o <= 1'b1;
                        wb_dat_o <= (hit && !wb_we_i) ? {24'h0, rd} : 32'h0;
                    end
                end
                QURS_ACK: begin
                    state_q <= QURS_DONE;
                    wb_ack_o <= 1'b0;
                end
                QURS_DONE: state_q <= QURS_IDLE;
                default: state_q <= QURS_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Output pins
    // ----------------------------------------------------------------
    // The host is expected to idle the receive lines high while asleep.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_o <= 1'b1;
            infrared_tx_out_o <= 1'b0;
            rts_n_o <= 1'b1;
            dtr_n_o <= 1'b1;
            receive_ready_pin_o <= 1'b1;
            transmit_ready_pin_o <= 1'b0;
            alert_o <= 1'b0;
            alert_oe_n_o <= 1'b1;
        end else begin
            serial_out_o <= !lctl_q[`QURS_LCTL_BRK];
            infrared_tx_out_o <= mctl_q[`QURS_MCTL_IR] & !lctl_q[`QURS_LCTL_BRK];
            rts_n_o <= !mctl_q[`QURS_MCTL_RTS];
            dtr_n_o <= !mctl_q[`QURS_MCTL_DTR];
            receive_ready_pin_o <= 1'b1;
            transmit_ready_pin_o <= 1'b0;
            alert_o <= 1'b0;
            alert_oe_n_o <= !(sel_s_q && !m68_s_q);
        end
    end
endmodule

// ==== testbench/qurs_channel_monitor.sv ====
`timescale 1ns/1ps
`include "qurs_defines.svh"
module qurs_channel_monitor
    import qurs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Straps and pins
    input wire logic alert_drive_select_i,
    input wire logic mode68_i,
    input wire logic serial_out_o,
    input wire logic infrared_tx_out_o,
    input wire logic rts_n_o,
    input wire logic dtr_n_o,
    input wire logic receive_ready_pin_o,
    input wire logic transmit_ready_pin_o,
    input wire logic alert_o,
    input wire logic alert_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    ack_pulse_a: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_wait_a: assert property (disable iff (rst_i)
        $rose(wb_cyc_i && wb_stb_i) |-> ##[1:3] wb_ack_o) else $error("no ack");
    pend_read_a: assert property (disable iff (rst_i) wb_ack_o && !wb_we_i &&
        wb_adr_i == `QURS_OFF_PEND |-> wb_dat_o == 32'h01) else $error("pending wrong");
    lstat_read_a: assert property (disable iff (rst_i) wb_ack_o && !wb_we_i &&
        wb_adr_i == `QURS_OFF_LSTAT |-> wb_dat_o == 32'h60) else $error("line stat wrong");
    reset_pins_a: assert property (rst_i |=> serial_out_o && !infrared_tx_out_o &&
        rts_n_o && dtr_n_o && receive_ready_pin_o && !transmit_ready_pin_o)
        else $error("pin reset state wrong");
    reset_alert_a: assert property (rst_i |=> alert_oe_n_o && !alert_o && !wb_ack_o)
        else $error("alert or ack active in reset");
    alert_float_a: assert property ((!rst_i && !alert_drive_select_i)[*5]
        |-> alert_oe_n_o) else $error("alert driven with select low");
    alert_drive_a: assert property ((!rst_i && alert_drive_select_i && !mode68_i)[*5]
        |-> !alert_oe_n_o && !alert_o) else $error("alert not driven low");
endmodule
bind qurs_channel qurs_channel_monitor qurs_channel_monitor_i (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .alert_drive_select_i, .mode68_i,
    .serial_out_o, .infrared_tx_out_o, .rts_n_o, .dtr_n_o, .receive_ready_pin_o,
    .transmit_ready_pin_o, .alert_o, .alert_oe_n_o);

// ==== testbench/qurs_pins_model.sv ====
`timescale 1ns/1ps
module qurs_pins_model
    import qurs_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Requested levels and pins
    input wire qurs_pins_s want_i,
    output qurs_pins_s pins_o
);
    // Levels change only after an edge, so the device's synchronisers see clean steps.
    always @(posedge clk_i) begin
        pins_o <= want_i;
    end
endmodule

// ==== testbench/qurs_channel_tb.sv ====
`timescale 1ns/1ps
module qurs_channel_tb
    import qurs_pkg::*;
;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sel_s = 0, m68 = 0;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0, rdat;
    logic ack, ser, irx, rts_n, dtr_n, rxr, txr, alert, oe_n;
    // Idle levels match the pins of all four channels straight after reset.
    qurs_pins_s want = '{modem_n: 4'hf, rx_ready_n: 4'hf, tx_ready_n: 4'h0};
    qurs_pins_s pins;
    qurs_byte_t q;
    int n_mismatch = 0, check_count = 0;
    qurs_byte_t exp_t [17] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
        8'h60, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
    always #12.5 clk_i = ~clk_i;
    qurs_pins_model qurs_pins_model_i (.clk_i(clk_i), .want_i(want), .pins_o(pins));
    qurs_channel qurs_channel_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .alert_drive_select_i(sel_s), .mode68_i(m68), .pins_i(pins),
        .serial_out_o(ser), .infrared_tx_out_o(irx), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
        .receive_ready_pin_o(rxr), .transmit_ready_pin_o(txr), .alert_o(alert),
        .alert_oe_n_o(oe_n));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input qurs_byte_t seen, input qurs_byte_t exp);
        check_count++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            n_mismatch++;
        end
    endtask
    // Caller enters just after an edge; the idle edge at the end keeps requests spaced.
    task automatic acc(input logic w, input logic [7:0] a, input qurs_byte_t d,
        output qurs_byte_t r);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= 4'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            wrap_up();
        end
        r = rdat[7:0];
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask
    task automatic rst_pulse(input int n);
        rst_i <= 1;
        repeat (n) @(posedge clk_i);
        rst_i <= 0;
    endtask
    // Pins are looked at mid-cycle, away from the edge that launches them.
    task automatic chk_pins();
        @(negedge clk_i);
        chk({1'b0, ser, irx, rts_n, dtr_n, rxr, txr, oe_n}, 8'h5d);
        @(posedge clk_i);
    endtask
    initial begin
        rst_pulse(10);
        for (int i = 0; i < 17; i++) begin
            acc(0, 8'(i * 4), 8'h00, q);
            chk(q, exp_t[i]);
        end
        acc(0, 8'h44, 8'h00, q);
        chk(q, 8'h00);
        chk_pins();
        $display("test reset_values done");
        for (int i = 0; i < 18; i++) acc(1, 8'(i * 4), 8'h5a, q);
        acc(0, 8'h28, 8'h00, q);
        chk(q, 8'h5a);
        rst_pulse(2);
        chk_pins();
        for (int i = 0; i < 17; i++) begin
            acc(0, 8'(i * 4), 8'h00, q);
            chk(q, (i < 2) ? 8'h5a : exp_t[i]);
        end
        $display("test divisor_survives_reset done");
        want <= '{modem_n: 4'h5, rx_ready_n: 4'h3, tx_ready_n: 4'h6};
        repeat (6) @(posedge clk_i);
        acc(0, 8'h24, 8'h00, q);
        chk(q, 8'haa);
        acc(0, 8'h24, 8'h00, q);
        chk(q, 8'ha0);
        acc(0, 8'h40, 8'h00, q);
        chk(q, 8'h39);
        rst_pulse(2);
        acc(0, 8'h24, 8'h00, q);
        chk(q, 8'ha0);
        $display("test modem_and_ready done");
        sel_s <= 1;
        repeat (6) @(posedge clk_i);
        chk({7'h0, oe_n}, 8'h00);
        m68 <= 1;
        repeat (6) @(posedge clk_i);
        chk({7'h0, oe_n}, 8'h01);
        sel_s <= 0;
        repeat (6) @(posedge clk_i);
        chk({7'h0, oe_n}, 8'h01);
        $display("test alert_drive done");
        wrap_up();
    end
endmodule
